// ==== rtl/spio_pkg.sv ====
// Package of constants, types and mask functions for the parallel I/O port.
package spio_pkg;

  // Port geometry.
  localparam int SPIO_W = 16;
  localparam int SPIO_NPORT = 2;
  localparam int PORT_B = 0;
  localparam int PORT_C = 1;

  // Package variants, named by pin count.
  localparam int VAR_20 = 20;
  localparam int VAR_28 = 28;
  localparam int VAR_44 = 44;

  // Register address layout: bit 2 picks the port, bits 1:0 the kind.
  localparam int ADDR_W = 4;
  localparam int ADDR_PORT_BIT = 2;
  localparam logic [1:0] KIND_DIR = 2'h0;
  localparam logic [1:0] KIND_LAT = 2'h1;
  localparam logic [1:0] KIND_PIN = 2'h2;
  localparam logic [1:0] KIND_ANS = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_PORT_TOP = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h8;
  localparam int CTRL_RESTORE_BIT = 0;

  // Bit masks.
  localparam logic [SPIO_W-1:0] ZERO_W = 16'h0000;
  localparam logic [SPIO_W-1:0] PRESENT_B_FULL = 16'hFFFF;
  localparam logic [SPIO_W-1:0] PRESENT_B_20 = 16'hF3F7;
  localparam logic [SPIO_W-1:0] PRESENT_C_44 = 16'h03FF;
  localparam logic [SPIO_W-1:0] ANALOG_SELECT_B_IMPL = 16'hF01F;
  localparam logic [SPIO_W-1:0] ANALOG_SELECT_B_BIT3 = 16'h0008;
  localparam logic [SPIO_W-1:0] ANALOG_SELECT_C_IMPL = 16'h0007;

  // Reset values.
  localparam logic [SPIO_W-1:0] LAT_RESET = 16'h0000;

  typedef logic [SPIO_W-1:0] spio_word_t;

  typedef struct packed {
    spio_word_t en;
    spio_word_t drive;
    spio_word_t out;
  } spio_periph_t;

  typedef struct packed {
    spio_word_t out;
    spio_word_t oe;
  } spio_pad_t;

  // Which port bits exist on a given variant.
  function automatic spio_word_t present_mask(input int port,
                                              input int variant);
    if (port == PORT_B) begin
      return (variant == VAR_20) ? PRESENT_B_20 : PRESENT_B_FULL;
    end
    return (variant == VAR_44) ? PRESENT_C_44 : ZERO_W;
  endfunction

  // Which analog select bits exist on a given variant.
  function automatic spio_word_t ansel_mask(input int port,
                                            input int variant);
    if (port == PORT_B) begin
      return (variant == VAR_20) ? (ANALOG_SELECT_B_IMPL & ~ANALOG_SELECT_B_BIT3) : ANALOG_SELECT_B_IMPL;
    end
    return (variant == VAR_44) ? ANALOG_SELECT_C_IMPL : ZERO_W;
  endfunction

endpackage

// ==== rtl/spio_port_mux.sv ====
// Output ownership and input gating multiplexers for one 16-bit port.
`timescale 1ns/1ps
module spio_port_mux
  import spio_pkg::*;
(
  // Port registers.
  input wire spio_word_t dir,
  input wire spio_word_t lat,
  input wire spio_word_t ans,
  input wire spio_word_t present,
  // Shared peripherals.
  input wire spio_periph_t periph,
  output spio_word_t periph_in,
  // Pins.
  input wire spio_word_t pin_in,
  output spio_pad_t pad,
  output spio_word_t digital_in
);

  wire spio_word_t periph_owns;
  wire spio_word_t port_drive;

  // Input-only functions never raise drive, so enable alone leaves
  // the pin a plain port pin.
  assign periph_owns = periph.en & periph.drive & present; // see RULE9

  // A driving peripheral turns the port driver off; an idle one
  // leaves it to the direction bit.
  assign port_drive = ~dir & ~periph_owns & present; // see RULE1 RULE2 RULE4

  assign pad.out = (periph_owns & periph.out) | (port_drive & lat);
  assign pad.oe = periph_owns | port_drive; // see RULE1

  // The input buffer is off for analog pins and absent bits.
  assign digital_in = pin_in & ~ans & present; // see RULE11 RULE8

  // The port's own output never loops into a peripheral input.
  assign periph_in = digital_in & ~port_drive; // see RULE3

endmodule

// ==== rtl/spio_top.sv ====
// Parallel I/O port: registers, pin sampling and deep-sleep hold.
//
// Functional notes
// RULE1: A driving enabled peripheral disables the port driver; pin stays readable.
// RULE2: An enabled but idle peripheral lets the port bit drive the pin.
// RULE3: Port output never feeds the input of a peripheral on that pin.
// RULE4: Direction one makes an input with driver off; zero makes an output.
// RULE5: Every reset sets all direction bits to one; the code sets present bits only, and absent bits reset to zero.
// RULE6: Latch register reads the latch; writes update the latch.
// RULE7: Pin register reads pin levels; writes go to the latch.
// RULE8: Absent port bits read zero in all registers and do nothing.
// RULE9: Pins shared with input-only functions behave as plain port pins.
// RULE10: Outputs frozen through deep sleep until software clears restore bit.
// RULE11: Analog select one disables the digital input buffer; zero enables it.
// RULE12: Group B analog select has bits 15-12 and 4-0; 11-5 read zero.
// RULE13: Group B analog select bit 3 is absent on the smallest variant.
// RULE14: Group C analog select has bits 2-0 only, absent on smaller variants.
// RULE15: Pin reads return zero while the analog select bit is set.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module spio_top
  import spio_pkg::*;
#(
  parameter int VARIANT = VAR_44
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,

  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire spio_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output spio_word_t reg_rdata,

  // Pins, one word per port.
  input wire spio_word_t [SPIO_NPORT-1:0] pin_in,
  output spio_word_t [SPIO_NPORT-1:0] pin_out,
  output spio_word_t [SPIO_NPORT-1:0] pin_oe,

  // Shared peripherals.
  input wire spio_periph_t [SPIO_NPORT-1:0] periph,
  output spio_word_t [SPIO_NPORT-1:0] periph_in,

  // Low-power control and status.
  input wire logic deep_sleep,
  output logic io_hold
);

  // True when the address selects a given port and register kind.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input int port,
                                   input logic [1:0] kind);
    logic port_sel;
    port_sel = (addr[ADDR_PORT_BIT] == port[0]);
    return (addr <= ADDR_PORT_TOP) && port_sel && (addr[1:0] == kind);
  endfunction

  // Per-port register state.
  spio_word_t dir_reg [SPIO_NPORT];
  spio_word_t dir_next [SPIO_NPORT];
  spio_word_t lat_reg [SPIO_NPORT];
  spio_word_t lat_next [SPIO_NPORT];
  spio_word_t ans_reg [SPIO_NPORT];
  spio_word_t ans_next [SPIO_NPORT];
  spio_word_t lvl_reg [SPIO_NPORT];
  spio_word_t lvl_next [SPIO_NPORT];

  // Pad drive state, frozen while holding.
  spio_word_t pout_reg [SPIO_NPORT];
  spio_word_t pout_next [SPIO_NPORT];
  spio_word_t poe_reg [SPIO_NPORT];
  spio_word_t poe_next [SPIO_NPORT];

  // Per-port read contributions, ORed into the read word.
  spio_word_t port_rd [SPIO_NPORT];

  // Hold and read-data state.
  logic hold_reg;
  logic hold_next;
  spio_word_t rdata_reg;
  spio_word_t rdata_next;

  // Global decode.
  wire logic ctrl_hit;
  wire logic ctrl_wr;
  wire logic ctrl_clear;
  wire logic freeze;
  wire spio_word_t ctrl_word;
  wire spio_word_t rd_word;

  assign ctrl_hit = (reg_addr == ADDR_CTRL);
  assign ctrl_wr = reg_wr && ctrl_hit;
  assign ctrl_clear = ctrl_wr && !reg_wdata[CTRL_RESTORE_BIT];

  // Entry into deep sleep sets the hold; a clear in the same cycle
  // loses, so a sleep request is never dropped.
  assign hold_next = deep_sleep || (hold_reg && !ctrl_clear); // see RULE10

  // Pads freeze from the cycle sleep is requested, not one late.
  assign freeze = deep_sleep || hold_reg; // see RULE10

  assign ctrl_word = {{(SPIO_W-1){1'b0}}, hold_reg};

  genvar gp;
  generate
    for (gp = 0; gp < SPIO_NPORT; gp++) begin : g_port
      // Variant masks are constants per port.
      localparam spio_word_t PRESENT = present_mask(gp, VARIANT);
      localparam spio_word_t ANS_IMPL = ansel_mask(gp, VARIANT);

      wire logic hit_dir_w;
      wire logic hit_lat_w;
      wire logic hit_pin_w;
      wire logic hit_ans_w;
      wire logic hit_dir_r;
      wire logic hit_lat_r;
      wire logic hit_pin_r;
      wire logic hit_ans_r;
      wire spio_pad_t pad;
      wire spio_word_t dig_in;

      assign hit_dir_w = reg_wr && reg_hit(reg_addr, gp, KIND_DIR);
      assign hit_lat_w = reg_wr && reg_hit(reg_addr, gp, KIND_LAT);
      assign hit_pin_w = reg_wr && reg_hit(reg_addr, gp, KIND_PIN);
      assign hit_ans_w = reg_wr && reg_hit(reg_addr, gp, KIND_ANS);
      assign hit_dir_r = reg_hit(reg_addr, gp, KIND_DIR);
      assign hit_lat_r = reg_hit(reg_addr, gp, KIND_LAT);
      assign hit_pin_r = reg_hit(reg_addr, gp, KIND_PIN);
      assign hit_ans_r = reg_hit(reg_addr, gp, KIND_ANS);

      // Absent bits are masked on write, so they store and read zero.
      assign dir_next[gp] = hit_dir_w ? (reg_wdata & PRESENT)
                                      : dir_reg[gp]; // see RULE4 RULE8

      // A write to either the latch or the pin register lands here.
      assign lat_next[gp] = (hit_lat_w || hit_pin_w)
                            ? (reg_wdata & PRESENT)
                            : lat_reg[gp]; // see RULE6 RULE7 RULE8

      // Only implemented analog select bits hold a value.
      assign ans_next[gp] = hit_ans_w ? (reg_wdata & ANS_IMPL)
                                      : ans_reg[gp]; // see RULE12 RULE14

      // Pins are sampled every cycle through the digital buffer.
      assign lvl_next[gp] = dig_in; // see RULE15

      assign pout_next[gp] = freeze ? pout_reg[gp] : pad.out;
      assign poe_next[gp] = freeze ? poe_reg[gp] : pad.oe;

      assign port_rd[gp] =
        ({SPIO_W{hit_dir_r}} & dir_reg[gp]) |
        ({SPIO_W{hit_lat_r}} & lat_reg[gp]) |
        ({SPIO_W{hit_pin_r}} & lvl_reg[gp]) |
        ({SPIO_W{hit_ans_r}} & ans_reg[gp]); // see RULE6 RULE7

      spio_port_mux u_mux (
        .dir(dir_reg[gp]),
        .lat(lat_reg[gp]),
        .ans(ans_reg[gp]),
        .present(PRESENT),
        .periph(periph[gp]),
        .periph_in(periph_in[gp]),
        .pin_in(pin_in[gp]),
        .pad(pad),
        .digital_in(dig_in)
      );

      // All present pins come up as inputs.
      always_ff @(posedge clock) begin
        if (!resetn) begin
          dir_reg[gp] <= PRESENT; // see RULE5
        end else begin
          dir_reg[gp] <= dir_next[gp];
        end
      end

      always_ff @(posedge clock) begin
        if (!resetn) begin
          lat_reg[gp] <= LAT_RESET;
        end else begin
          lat_reg[gp] <= lat_next[gp];
        end
      end

      // Analog select comes up set on every implemented bit.
      always_ff @(posedge clock) begin
        if (!resetn) begin
          ans_reg[gp] <= ANS_IMPL; // see RULE13 RULE14
        end else begin
          ans_reg[gp] <= ans_next[gp];
        end
      end

      always_ff @(posedge clock) begin
        if (!resetn) begin
          lvl_reg[gp] <= ZERO_W;
        end else begin
          lvl_reg[gp] <= lvl_next[gp];
        end
      end

      // Pads come out of reset undriven, matching the input default.
      always_ff @(posedge clock) begin
        if (!resetn) begin
          pout_reg[gp] <= ZERO_W;
          poe_reg[gp] <= ZERO_W;
        end else begin
          pout_reg[gp] <= pout_next[gp];
          poe_reg[gp] <= poe_next[gp];
        end
      end

      assign pin_out[gp] = pout_reg[gp];
      assign pin_oe[gp] = poe_reg[gp];
    end
  endgenerate

  // Unmapped addresses read zero since no hit term is set.
  assign rd_word = port_rd[PORT_B] | port_rd[PORT_C] |
                   ({SPIO_W{ctrl_hit}} & ctrl_word);

  // Read data stands for exactly the cycle after the strobe.
  assign rdata_next = reg_rd ? rd_word : ZERO_W;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_reg <= ZERO_W;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign io_hold = hold_reg;

endmodule

// ==== test/spio_top_assertions.sv ====
// Checker for pad ownership, sleep hold and register masks of the port.
`timescale 1ns/1ps
module spio_chk
  import spio_pkg::*;
#(
  parameter int VARIANT = VAR_44
)
(
  // Clock, reset and register port.
  input wire logic clock,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire spio_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire spio_word_t reg_rdata,
  // Pins and peripherals.
  input wire spio_word_t [SPIO_NPORT-1:0] pin_in,
  input wire spio_word_t [SPIO_NPORT-1:0] pin_out,
  input wire spio_word_t [SPIO_NPORT-1:0] pin_oe,
  input wire spio_periph_t [SPIO_NPORT-1:0] periph,
  input wire spio_word_t [SPIO_NPORT-1:0] periph_in,
  // Low power.
  input wire logic deep_sleep,
  input wire logic io_hold
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire spio_word_t pc = (VARIANT == VAR_44) ? PRESENT_C_44 : ZERO_W;
  wire spio_word_t own_b = periph[0].en & periph[0].drive;
  wire spio_word_t own_c = periph[1].en & periph[1].drive;
  wire ctrl_wr = reg_wr && reg_addr == ADDR_CTRL;
  wire c_read = reg_rd && reg_addr[ADDR_PORT_BIT] && reg_addr <= ADDR_PORT_TOP;

  reset_quiet_a: assert property (disable iff (1'b0)
    !resetn |=> pin_oe == '0 && reg_rdata == '0 && io_hold == 1'b0)
    else $error("outputs not quiet after reset");
  owner_drive_a: assert property (
    !deep_sleep && !io_hold |=> (pin_oe[0] & $past(own_b)) == $past(own_b)
    && ((pin_out[0] ^ $past(periph[0].out)) & $past(own_b)) == '0)
    else $error("peripheral does not own its pin");
  // A bit that the port drives (enabled next cycle, not peripheral-owned)
  // must have been kept away from the peripheral input.
  loop_block_a: assert property (
    !deep_sleep && !io_hold |=>
    ($past(periph_in[0]) & pin_oe[0] & ~$past(own_b)) == '0
    && ($past(periph_in[1]) & pin_oe[1] & ~$past(own_c)) == '0)
    else $error("port output loops into peripheral input");
  absent_pad_a: assert property ((pin_oe[1] & ~pc) == '0)
    else $error("absent pin driven");
  sleep_freeze_a: assert property (
    deep_sleep |=> $stable(pin_out) && $stable(pin_oe))
    else $error("pins moved in deep sleep");
  hold_set_a: assert property (deep_sleep |=> io_hold)
    else $error("hold not set by deep sleep");
  hold_keep_a: assert property (
    io_hold && !ctrl_wr |=> io_hold && $stable(pin_out) && $stable(pin_oe))
    else $error("hold lost without software clear");
  analog_select_b_read_a: assert property (
    reg_rd && reg_addr == 4'h3 |=> (reg_rdata & ~ANALOG_SELECT_B_IMPL) == '0)
    else $error("unimplemented analog B bit reads one");
  analog_select_c_read_a: assert property (
    reg_rd && reg_addr == 4'h7 |=> (reg_rdata & ~(ANALOG_SELECT_C_IMPL & pc)) == '0)
    else $error("unimplemented analog C bit reads one");
  absent_read_a: assert property (
    c_read && reg_addr[1:0] != KIND_ANS |=> (reg_rdata & ~pc) == '0)
    else $error("absent port C bit reads one");

  cover property (own_b != '0 && !io_hold);
  cover property (deep_sleep ##1 io_hold);
  cover property (io_hold && ctrl_wr);
endmodule

bind spio_top spio_chk #(.VARIANT(VARIANT)) u_chk (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .periph(periph), .periph_in(periph_in),
  .deep_sleep(deep_sleep), .io_hold(io_hold));

// ==== test/spio_pins.sv ====
// Model of the external pins: driven level where enabled, else wandering.
`timescale 1ns/1ps
module spio_pins
  import spio_pkg::*;
(
  // Device side.
  input wire logic clock,
  input wire spio_word_t [SPIO_NPORT-1:0] pin_out,
  input wire spio_word_t [SPIO_NPORT-1:0] pin_oe,
  // Level seen by the device.
  output spio_word_t [SPIO_NPORT-1:0] pin_in
);
  // Floating pins change every cycle so a stale level never passes.
  spio_word_t float_reg = 16'h5A5A;
  always @(posedge clock) begin
    float_reg <= ~float_reg;
  end
  assign pin_in[0] = (pin_out[0] & pin_oe[0]) | (float_reg & ~pin_oe[0]);
  assign pin_in[1] = (pin_out[1] & pin_oe[1]) | (float_reg & ~pin_oe[1]);
endmodule

// ==== test/tb_spio_top.sv ====
// Register-level testbench for the parallel I/O port.
`timescale 1ns/1ps
module tb_spio_top;
  import spio_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  spio_word_t reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  spio_word_t reg_rdata;
  spio_word_t rdata20;
  spio_word_t [SPIO_NPORT-1:0] pin_in, pin_out, pin_oe, periph_in;
  spio_periph_t [SPIO_NPORT-1:0] periph = '0;
  logic deep_sleep = 1'b0;
  logic io_hold;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #10 clock = ~clock;

  spio_top #(.VARIANT(VAR_44)) dut (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .periph(periph),
    .periph_in(periph_in), .deep_sleep(deep_sleep), .io_hold(io_hold));
  spio_pins pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));
  // The smallest variant shares the register bus; only its reads are checked.
  spio_top #(.VARIANT(VAR_20)) dut20 (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata20), .pin_in(pin_in),
    .pin_out(), .pin_oe(), .periph('0),
    .periph_in(), .deep_sleep(deep_sleep), .io_hold());

  task automatic close_out;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input spio_word_t exp,
                     input spio_word_t got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input spio_word_t d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input spio_word_t exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata);
  endtask

  // Pads are registered behind the register, so allow the full path.
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd(4'h0, 16'hFFFF);
    chk("dir B small", PRESENT_B_20, rdata20);
    rd(4'h4, PRESENT_C_44);
    rd(4'h3, ANALOG_SELECT_B_IMPL);
    chk("ansel B small", ANALOG_SELECT_B_IMPL & ~ANALOG_SELECT_B_BIT3, rdata20);
    rd(4'h7, ANALOG_SELECT_C_IMPL);
    chk("ansel C small", ZERO_W, rdata20);
    wr(4'h1, 16'hA5C3);
    rd(4'h1, 16'hA5C3);
    wr(4'h2, 16'h1234);
    rd(4'h1, 16'h1234);
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0000);
    settle;
    chk("pin_oe", 16'hFFFF, pin_oe[0]);
    chk("pin_out", 16'h1234, pin_out[0]);
    rd(4'h2, 16'h1234);
    wr(4'h3, 16'hFFFF);
    rd(4'h3, ANALOG_SELECT_B_IMPL);
    settle;
    rd(4'h2, 16'h1234 & ~ANALOG_SELECT_B_IMPL);
    wr(4'h3, 16'h0000);
    @(posedge clock);
    periph[0] <= '{en: 16'h00FF, drive: 16'h000F, out: 16'h0005};
    settle;
    chk("pin_out", 16'h1235, pin_out[0]);
    chk("pin_oe", 16'hFFFF, pin_oe[0]);
    chk("periph_in", 16'h0005, periph_in[0]);
    rd(4'h2, 16'h1235);
    @(posedge clock);
    periph[0] <= '0;
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'hFFFF);
    rd(4'h5, PRESENT_C_44);
    settle;
    chk("pin_oe C", PRESENT_C_44, pin_oe[1]);
    wr(4'h7, 16'hFFFF);
    rd(4'h7, ANALOG_SELECT_C_IMPL);
    rd(4'h9, 16'h0000);
    @(posedge clock);
    deep_sleep <= 1'b1;
    wr(4'h1, 16'h00FF);
    settle;
    chk("pin_out", 16'h1234, pin_out[0]);
    @(posedge clock);
    deep_sleep <= 1'b0;
    settle;
    chk("pin_out", 16'h1234, pin_out[0]);
    chk("io_hold", 16'h0001, {15'h0000, io_hold});
    wr(ADDR_CTRL, 16'h0000);
    settle;
    chk("pin_out", 16'h00FF, pin_out[0]);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd(4'h0, 16'hFFFF);
    rd(4'h1, LAT_RESET);
    close_out;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      close_out;
    end
  end
endmodule
